// [rtl/global_pins_params.svh]
`ifndef GLOBAL_PINS_PARAMS_SVH
`define GLOBAL_PINS_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_GPIO 8'h04
`define OFS_IRQ_CFG 8'h08
`define OFS_STATE 8'h0c
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14

// ****************************************
// Control register fields
// ****************************************
`define BIT_EXT_SW 0
`define BIT_RATE_FAM 1
`define BIT_DIG1_FAM 2
`define BIT_DIG2_FAM 3
`define BIT_RF_PIN_EN 4
`define BIT_LOCK_PIN_EN 5
`define BIT_MAN_SEL 6
`define CTRL_WIDTH 7
`define CTRL_RESET 7'h00

// ****************************************
// General-purpose pin register fields
// ****************************************
`define BIT_GP_DIR 0
`define BIT_GP_OUT 1
`define BIT_GP_STATE 8
`define GPIO_RESET 2'h0

// ****************************************
// Interrupt configuration fields
// ****************************************
`define BIT_LOS_MODE 0
`define BIT_IRQ_HIGH 1
`define BIT_IRQ_OD 2
`define BIT_IRQ_GPO 3
`define BIT_IRQ_GPO_VAL 4
`define IRQ_CFG_WIDTH 5
`define IRQ_CFG_RESET 5'h00

// ****************************************
// Event bits (status and mask share layout)
// ****************************************
`define EV_REF_FAIL 0
`define EV_LOCK_LOST 1
`define EV_ACT_LOST 2
`define EV_SER_BYTE 3
`define EV_WIDTH 4
`define EV_RESET 4'h0

// ****************************************
// Timing
// ****************************************
`define SYNC_STAGES 2
`define SER_BITS 8

`endif

// [rtl/global_pins_pkg.sv]
package global_pins_pkg;
	typedef logic [7:0] addr_type;
	typedef logic [31:0] word_type;
	typedef logic [7:0] ser_byte_type;
	typedef logic [2:0] bit_cnt_type;
	// Pin vector order for the synchroniser
	typedef enum logic [2:0] {
		PIN_FAST_SOURCE_SWITCH_PIN,
		PIN_GP4,
		PIN_CS_N,
		PIN_SCLK,
		PIN_SDI,
		PIN_CPHA,
		PIN_CPOL
	} pin_idx_type;
endpackage : global_pins_pkg

// [rtl/serial_if.sv]
`timescale 1ns/1ns
`default_nettype none
// Byte path between the serial shifter and the core
interface serial_if;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic busy;
	logic [7:0] tx_byte;
	modport shifter (output rx_byte, output rx_valid, output busy, input tx_byte);
	modport core (input rx_byte, input rx_valid, input busy, output tx_byte);
endinterface : serial_if
`default_nettype wire

// [rtl/serial_shifter.sv]
`timescale 1ns/1ns
`default_nettype none
`include "global_pins_params.svh"
module serial_shifter
	import global_pins_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n_s,
	input wire logic sclk_s,
	input wire logic sdi_s,
	input wire logic cpha_s,
	input wire logic cpol_s,
	output logic sdo_o,
	output logic sdo_oe,
	serial_if.shifter sif
);
	// ****************************************
	// Edge finding on the sampled serial clock
	// ****************************************
	logic sclk_prev_reg;
	logic cs_prev_reg;
	logic edge_seen;
	logic lead_edge;
	logic trail_edge;
	logic cap_edge;
	logic launch_edge;
	logic cs_fall;
	bit_cnt_type cnt_reg;
	ser_byte_type rx_sr_reg;
	ser_byte_type tx_sr_reg;

	// Leading edge leaves the idle level, trailing edge returns to it
	assign edge_seen = (sclk_s != sclk_prev_reg) && !cs_n_s;
	assign lead_edge = edge_seen && (sclk_prev_reg == cpol_s);
	assign trail_edge = edge_seen && (sclk_prev_reg != cpol_s);
	assign cap_edge = cpha_s ? trail_edge : lead_edge;
	assign launch_edge = cpha_s ? lead_edge : trail_edge;
	assign cs_fall = cs_prev_reg && !cs_n_s;

	// History of clock and select
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
		end else begin
			sclk_prev_reg <= sclk_s;
			cs_prev_reg <= cs_n_s;
		end
	end

	// Receive side; traffic with select high is dropped
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 3'h0;
			rx_sr_reg <= 8'h00;
			sif.rx_valid <= 1'b0;
			sif.rx_byte <= 8'h00;
		end else begin
			sif.rx_valid <= 1'b0;
			if (cs_n_s) begin
				cnt_reg <= 3'h0;
			end else if (cap_edge) begin
				rx_sr_reg <= {rx_sr_reg[6:0], sdi_s};
				cnt_reg <= cnt_reg + 3'h1;
				if (cnt_reg == 3'h7) begin
					sif.rx_byte <= {rx_sr_reg[6:0], sdi_s};
					sif.rx_valid <= 1'b1;
				end
			end
		end
	end

	// Transmit side: first bit ready at select fall, reload per byte
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_sr_reg <= 8'h00;
		end else if (cs_fall || (cap_edge && cnt_reg == 3'h7)) begin
			tx_sr_reg <= sif.tx_byte;
		end else if (launch_edge && cnt_reg != 3'h0) begin
			tx_sr_reg <= {tx_sr_reg[6:0], 1'b0};
		end
	end

	// Output driven only while selected
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sdo_o <= 1'b0;
			sdo_oe <= 1'b0;
			sif.busy <= 1'b0;
		end else begin
			sdo_o <= tx_sr_reg[7];
			sdo_oe <= !cs_n_s;
			sif.busy <= !cs_n_s;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_cs_ignore: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cs_n_s |=> !sif.rx_valid)
		else $error("byte accepted while deselected");
	a_capture_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!cs_n_s && cnt_reg == 3'h0 && (cpha_s ? trail_edge : lead_edge))
		|=> cnt_reg == 3'h1 && rx_sr_reg[0] == $past(sdi_s))
		else $error("bit not taken on capture edge");
	a_idle_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!cs_n_s && !cpha_s && edge_seen && sclk_s == cpol_s) |=> $stable(cnt_reg))
		else $error("return to idle taken as capture");
endmodule : serial_shifter
`default_nettype wire

// [rtl/global_pin_status_strap.sv]
`timescale 1ns/1ns
`default_nettype none
`include "global_pins_params.svh"
// Behaviour
// - Low reset asynchronously clears all logic except the select synchroniser and select history, which preset high
// - Source-switch pin latched at reset release
// - Switch pin selects group A or B
// - Rate strap sets family defaults
// - Strap pin becomes general-purpose pin four
// - Enabled ref-fail pin mirrors latched status
// - Enabled lock pin shows loop lock
// - Mode bit picks interrupt or loss
// - Interrupt pin polarity, drive, general output
// - Loss mode shows live activity
// - Data in on input, out on output
// - Phase pin picks capture edge
// - Polarity pin sets idle level
module global_pin_status_strap
	import global_pins_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire logic fast_source_switch_pin,
	input wire logic rate_family_strap_pin_i,
	output logic rate_family_strap_pin_o,
	output logic rate_family_strap_pin_oe,
	input wire logic ref_fail_event,
	input wire logic loop_locked,
	input wire logic activity_group_a,
	input wire logic activity_group_b,
	output logic ref_select_group_b,
	output logic rate_family_select,
	output logic digital_out1_family,
	output logic digital_out2_family,
	output logic ref_fail_indicator_o,
	output logic ref_fail_indicator_oe,
	output logic lock_out,
	output logic interrupt_request_out_o,
	output logic interrupt_request_out_oe,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic cpha,
	input wire logic cpol,
	output logic sdo_o,
	output logic sdo_oe
);
	// ****************************************
	// Reset release and pin synchronisers
	// ****************************************
	logic rst_meta_reg;
	logic rst_sync_n;
	logic run_reg;
	logic release_pulse;
	logic [6:0] pin_meta_reg;
	logic [6:0] pin_sync_reg;
	logic [6:0] pin_raw;
	logic fast_source_switch_pin_s;
	logic gp4_s;

	// Assert at once, release after two clean edges
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n <= rst_meta_reg;
		end
	end

	// First cycle out of reset; straps sampled here
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			run_reg <= 1'b0;
		end else begin
			run_reg <= 1'b1;
		end
	end
	// Gated by the synced reset so no capture is seen while still held
	assign release_pulse = rst_sync_n && !run_reg;

	assign pin_raw[PIN_FAST_SOURCE_SWITCH_PIN] = fast_source_switch_pin;
	assign pin_raw[PIN_GP4] = rate_family_strap_pin_i;
	assign pin_raw[PIN_CS_N] = cs_n;
	assign pin_raw[PIN_SCLK] = sclk;
	assign pin_raw[PIN_SDI] = sdi;
	assign pin_raw[PIN_CPHA] = cpha;
	assign pin_raw[PIN_CPOL] = cpol;

	// Runs on the raw reset so straps are valid at release
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pin_meta_reg <= 7'h04;
			pin_sync_reg <= 7'h04;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
		end
	end
	assign fast_source_switch_pin_s = pin_sync_reg[PIN_FAST_SOURCE_SWITCH_PIN];
	assign gp4_s = pin_sync_reg[PIN_GP4];

	// ****************************************
	// Register file
	// ****************************************
	logic [`CTRL_WIDTH-1:0] ctrl_reg;
	logic [1:0] gpio_reg;
	logic [`IRQ_CFG_WIDTH-1:0] irq_cfg_reg;
	logic [`EV_WIDTH-1:0] irq_status_reg;
	logic [`EV_WIDTH-1:0] irq_mask_reg;
	logic [`EV_WIDTH-1:0] ev_set;
	logic [`EV_WIDTH-1:0] ev_clr;
	logic locked_prev_reg;
	logic act_prev_reg;
	logic sel_activity;
	logic sel_b;
	word_type rdata_next;
	serial_if sif ();

	function automatic logic hit(input addr_type a, input addr_type ofs);
		hit = (a == ofs);
	endfunction : hit

	// Control; defaults for switch and families come from straps
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_reg <= `CTRL_RESET;
		end else if (release_pulse) begin
			ctrl_reg[`BIT_EXT_SW] <= fast_source_switch_pin_s;
			ctrl_reg[`BIT_RATE_FAM] <= gp4_s;
			ctrl_reg[`BIT_DIG1_FAM] <= gp4_s;
			ctrl_reg[`BIT_DIG2_FAM] <= gp4_s;
		end else if (reg_wr && hit(reg_addr, `OFS_CTRL)) begin
			ctrl_reg <= reg_wdata[`CTRL_WIDTH-1:0];
		end
	end

	// General-purpose pin and interrupt configuration
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			gpio_reg <= `GPIO_RESET;
			irq_cfg_reg <= `IRQ_CFG_RESET;
			irq_mask_reg <= `EV_RESET;
		end else if (reg_wr) begin
			if (hit(reg_addr, `OFS_GPIO)) begin
				gpio_reg <= reg_wdata[1:0];
			end
			if (hit(reg_addr, `OFS_IRQ_CFG)) begin
				irq_cfg_reg <= reg_wdata[`IRQ_CFG_WIDTH-1:0];
			end
			if (hit(reg_addr, `OFS_IRQ_MASK)) begin
				irq_mask_reg <= reg_wdata[`EV_WIDTH-1:0];
			end
		end
	end

	// ****************************************
	// Reference selection and events
	// ****************************************
	// Pin steers only when external switching is on
	assign sel_b = ctrl_reg[`BIT_EXT_SW] ? fast_source_switch_pin_s : ctrl_reg[`BIT_MAN_SEL];
	assign sel_activity = sel_b ? activity_group_b : activity_group_a;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			locked_prev_reg <= 1'b0;
			act_prev_reg <= 1'b0;
		end else begin
			locked_prev_reg <= loop_locked;
			act_prev_reg <= sel_activity;
		end
	end

	always_comb begin
		ev_set = `EV_RESET;
		ev_set[`EV_REF_FAIL] = ref_fail_event;
		ev_set[`EV_LOCK_LOST] = locked_prev_reg && !loop_locked;
		ev_set[`EV_ACT_LOST] = act_prev_reg && !sel_activity;
		ev_set[`EV_SER_BYTE] = sif.rx_valid;
	end
	assign ev_clr = (reg_wr && hit(reg_addr, `OFS_IRQ_STATUS)) ?
		reg_wdata[`EV_WIDTH-1:0] : `EV_RESET;

	// Sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_status_reg <= `EV_RESET;
		end else begin
			irq_status_reg <= (irq_status_reg & ~ev_clr) | ev_set;
		end
	end
	assign irq = |(irq_status_reg & irq_mask_reg);

	// Read data in the cycle after the strobe, zero when unmapped
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (hit(reg_addr, `OFS_CTRL)) begin
			rdata_next[`CTRL_WIDTH-1:0] = ctrl_reg;
		end else if (hit(reg_addr, `OFS_GPIO)) begin
			rdata_next[1:0] = gpio_reg;
			rdata_next[`BIT_GP_STATE] = gp4_s;
		end else if (hit(reg_addr, `OFS_IRQ_CFG)) begin
			rdata_next[`IRQ_CFG_WIDTH-1:0] = irq_cfg_reg;
		end else if (hit(reg_addr, `OFS_STATE)) begin
			rdata_next[3:0] = {sif.busy, sel_activity, loop_locked, sel_b};
			rdata_next[15:8] = sif.rx_byte;
		end else if (hit(reg_addr, `OFS_IRQ_STATUS)) begin
			rdata_next[`EV_WIDTH-1:0] = irq_status_reg;
		end else if (hit(reg_addr, `OFS_IRQ_MASK)) begin
			rdata_next[`EV_WIDTH-1:0] = irq_mask_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	logic irq_level;

	// Interrupt level with polarity, or the plain output value
	assign irq_level = irq_cfg_reg[`BIT_IRQ_GPO] ? irq_cfg_reg[`BIT_IRQ_GPO_VAL] :
		(irq ~^ irq_cfg_reg[`BIT_IRQ_HIGH]);

	// Strap pin stays an input until software turns it round
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rate_family_strap_pin_o <= 1'b0;
			rate_family_strap_pin_oe <= 1'b0;
		end else begin
			rate_family_strap_pin_o <= gpio_reg[`BIT_GP_OUT];
			rate_family_strap_pin_oe <= gpio_reg[`BIT_GP_DIR];
		end
	end

	// Status indicators
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ref_fail_indicator_o <= 1'b0;
			ref_fail_indicator_oe <= 1'b0;
			lock_out <= 1'b0;
			ref_select_group_b <= 1'b0;
		end else begin
			ref_fail_indicator_o <= irq_status_reg[`EV_REF_FAIL];
			ref_fail_indicator_oe <= ctrl_reg[`BIT_RF_PIN_EN];
			lock_out <= ctrl_reg[`BIT_LOCK_PIN_EN] && loop_locked;
			ref_select_group_b <= sel_b;
		end
	end

	// Shared pin; open drain only ever pulls low
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			interrupt_request_out_o <= 1'b0;
			interrupt_request_out_oe <= 1'b0;
		end else if (irq_cfg_reg[`BIT_LOS_MODE]) begin
			interrupt_request_out_o <= !sel_activity;
			interrupt_request_out_oe <= 1'b1;
		end else if (irq_cfg_reg[`BIT_IRQ_OD]) begin
			interrupt_request_out_o <= 1'b0;
			interrupt_request_out_oe <= !irq_level;
		end else begin
			interrupt_request_out_o <= irq_level;
			interrupt_request_out_oe <= 1'b1;
		end
	end

	assign rate_family_select = ctrl_reg[`BIT_RATE_FAM];
	assign digital_out1_family = ctrl_reg[`BIT_DIG1_FAM];
	assign digital_out2_family = ctrl_reg[`BIT_DIG2_FAM];

	// ****************************************
	// Serial host port
	// ****************************************
	// Shifter returns the event status byte on every frame
	assign sif.tx_byte = {4'h0, irq_status_reg};

	serial_shifter u_shifter (
		.clk_sys(clk_sys),
		.rst_n(rst_sync_n),
		.cs_n_s(pin_sync_reg[PIN_CS_N]),
		.sclk_s(pin_sync_reg[PIN_SCLK]),
		.sdi_s(pin_sync_reg[PIN_SDI]),
		.cpha_s(pin_sync_reg[PIN_CPHA]),
		.cpol_s(pin_sync_reg[PIN_CPOL]),
		.sdo_o(sdo_o),
		.sdo_oe(sdo_oe),
		.sif(sif.shifter)
	);

	// ****************************************
	// Checks
	// ****************************************
	a_reset_clears_state: assert property (@(posedge clk_sys)
		!resetn |=> !rst_sync_n && irq_status_reg == `EV_RESET && !lock_out)
		else $error("state not cleared in reset");
	a_strap_switch_latch: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		release_pulse |=> ctrl_reg[`BIT_EXT_SW] == $past(fast_source_switch_pin_s))
		else $error("switch strap not latched");
	a_strap_family_latch: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		release_pulse |=> {digital_out2_family, digital_out1_family, rate_family_select}
			== {3{$past(gp4_s)}})
		else $error("family strap not latched");
	a_group_follows_pin: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ctrl_reg[`BIT_EXT_SW] |=> ref_select_group_b == $past(fast_source_switch_pin_s))
		else $error("group select not from pin");
	a_gp_pin_drive: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		!release_pulse ##1 1'b1 |-> rate_family_strap_pin_oe == $past(gpio_reg[`BIT_GP_DIR])
			&& rate_family_strap_pin_o == $past(gpio_reg[`BIT_GP_OUT]))
		else $error("general pin drive wrong");
	a_ref_fail_mirror: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		ctrl_reg[`BIT_RF_PIN_EN] |=> ref_fail_indicator_oe
			&& ref_fail_indicator_o == $past(irq_status_reg[`EV_REF_FAIL]))
		else $error("ref-fail pin not mirrored");
	a_lock_pin_low: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		!ctrl_reg[`BIT_LOCK_PIN_EN] |=> !lock_out)
		else $error("lock pin not low when off");
	a_loss_mode_live: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		irq_cfg_reg[`BIT_LOS_MODE] |=> interrupt_request_out_oe
			&& interrupt_request_out_o == !$past(sel_activity))
		else $error("loss mode does not show activity");
	a_irq_open_drain: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		(!irq_cfg_reg[`BIT_LOS_MODE] && irq_cfg_reg[`BIT_IRQ_OD]) |=> !interrupt_request_out_o)
		else $error("open drain drives high");
	a_irq_push_pull: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		(irq_cfg_reg[`IRQ_CFG_WIDTH-1:0] == 5'h02 && irq) |=> interrupt_request_out_o)
		else $error("interrupt mode not asserted");
endmodule : global_pin_status_strap
`default_nettype wire

// [tb/spi_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Behavioural serial bus master; its clock stands still between frames
module spi_host_model (
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	output logic cpol,
	output logic cpha,
	input wire logic sdo_o,
	input wire logic sdo_oe
);
	logic sdo_last = 1'b0;
	// A released data line shows the inverse of its last value, never a held copy
	wire logic sdo_lvl = sdo_oe ? sdo_o : ~sdo_last;

	// Track the last driven data level
	always @(sdo_o or sdo_oe) begin
		if (sdo_oe)
			sdo_last = sdo_o;
	end

	// Idle pins before the first frame
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		cpol = 1'b0;
		cpha = 1'b0;
	end

	// One byte, MSB first; sel low keeps select high to send ignored traffic
	task automatic xfer(input logic pol, input logic pha, input logic sel,
		input logic [7:0] tx, output logic [7:0] rx);
		int i;
		#2;
		cpol = pol;
		cpha = pha;
		sclk = pol;
		#200;
		cs_n = ~sel;
		for (i = 7; i >= 0; i--) begin
			if (!pha)
				sdi = tx[i];
			#62;
			sclk = ~pol;
			if (pha)
				sdi = tx[i];
			else
				rx[i] = sdo_lvl;
			#63;
			sclk = pol;
			if (pha)
				rx[i] = sdo_lvl;
		end
		#62;
		cs_n = 1'b1;
		sdi = ~sdi;
	endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "global_pins_params.svh"
module tb
	import global_pins_pkg::*;
;
	logic clk_sys = 1'b0;
	logic resetn, reg_wr, reg_rd, fast_source_switch_pin, strap_ext, ref_fail_event;
	logic loop_locked, activity_group_a, activity_group_b;
	addr_type reg_addr;
	word_type reg_wdata, reg_rdata, rd_val;
	logic irq, strap_o, strap_oe, ref_select_group_b, rate_family_select;
	logic digital_out1_family, digital_out2_family, rf_o, rf_oe, lock_out;
	logic int_o, int_oe, sdo_o, sdo_oe, cs_n, sclk, sdi, cpha, cpol;
	logic [7:0] rx;
	int error_cnt = 0;
	int checks = 0;
	logic [4:0] cfg_t [5] = '{5'h00, 5'h02, 5'h04, 5'h18, 5'h08};
	logic [1:0] pin_t [5] = '{2'b10, 2'b11, 2'b10, 2'b11, 2'b10};
	// Strap pin level: device wins while it drives, else the outside driver
	wire logic strap_lvl = strap_oe ? strap_o : strap_ext;

	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;

	global_pin_status_strap i_global_pin_status_strap (.clk_sys(clk_sys), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .fast_source_switch_pin(fast_source_switch_pin),
		.rate_family_strap_pin_i(strap_lvl), .rate_family_strap_pin_o(strap_o),
		.rate_family_strap_pin_oe(strap_oe), .ref_fail_event(ref_fail_event),
		.loop_locked(loop_locked), .activity_group_a(activity_group_a),
		.activity_group_b(activity_group_b), .ref_select_group_b(ref_select_group_b),
		.rate_family_select(rate_family_select), .digital_out1_family(digital_out1_family),
		.digital_out2_family(digital_out2_family), .ref_fail_indicator_o(rf_o),
		.ref_fail_indicator_oe(rf_oe), .lock_out(lock_out), .interrupt_request_out_o(int_o),
		.interrupt_request_out_oe(int_oe), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .cpha(cpha),
		.cpol(cpol), .sdo_o(sdo_o), .sdo_oe(sdo_oe));

	spi_host_model i_spi_host_model (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .cpol(cpol),
		.cpha(cpha), .sdo_o(sdo_o), .sdo_oe(sdo_oe));

	// ****************************************
	// Access and check tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	task automatic wr(input addr_type a, input word_type d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rc(input string what, input addr_type a, input word_type exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
		chk(what, rd_val, exp);
	endtask : rc

	task automatic rf_pulse;
		@(posedge clk_sys) ref_fail_event <= 1'b1;
		@(posedge clk_sys) ref_fail_event <= 1'b0;
	endtask : rf_pulse

	// Straps are held steady across release so capture cannot race them
	task automatic do_reset(input logic sw, input logic strap);
		@(posedge clk_sys);
		resetn <= 1'b0;
		fast_source_switch_pin <= sw;
		strap_ext <= strap;
		cyc(10);
		chk("rst_rdata", reg_rdata, 32'h0);
		chk("rst_pins", {irq, strap_oe, rf_oe, int_oe, sdo_oe, lock_out}, 32'h0);
		@(posedge clk_sys) resetn <= 1'b1;
		cyc(6);
	endtask : do_reset

	task automatic conclude;
		if (error_cnt == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// Watchdog sized well beyond the expected run of some 9 us
	initial begin
		#300000;
		error_cnt++;
		conclude();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		{resetn, reg_wr, reg_rd, fast_source_switch_pin, strap_ext, ref_fail_event} = '0;
		{loop_locked, activity_group_a, activity_group_b} = 3'b111;
		reg_addr = '0;
		reg_wdata = '0;
		do_reset(1'b1, 1'b1);
		rc("ctrl_strap_hi", `OFS_CTRL, 32'h0f);
		chk("family_hi", {rate_family_select, digital_out1_family, digital_out2_family}, 3'h7);
		for (int v = 0; v < 3; v++) begin
			@(posedge clk_sys) fast_source_switch_pin <= v[0];
			cyc(8);
			chk("group_ext", ref_select_group_b, v[0]);
		end
		wr(`OFS_CTRL, 32'h70);
		cyc(3);
		chk("group_man", ref_select_group_b, 1'b1);
		do_reset(1'b0, 1'b0);
		rc("ctrl_strap_lo", `OFS_CTRL, 32'h00);
		chk("family_lo", {rate_family_select, digital_out1_family, digital_out2_family}, 3'h0);
		@(posedge clk_sys) fast_source_switch_pin <= 1'b1;
		cyc(8);
		chk("group_noext", ref_select_group_b, 1'b0);
		// General-purpose pin as input, then driven high and low
		@(posedge clk_sys) strap_ext <= 1'b1;
		cyc(6);
		rc("gp_in", `OFS_GPIO, 32'h100);
		wr(`OFS_GPIO, 32'h3);
		@(posedge clk_sys) strap_ext <= 1'b0;
		cyc(6);
		chk("gp_drive", {strap_oe, strap_o}, 2'b11);
		rc("gp_out_hi", `OFS_GPIO, 32'h103);
		wr(`OFS_GPIO, 32'h1);
		cyc(6);
		rc("gp_out_lo", `OFS_GPIO, 32'h001);
		// Reference-fail and lock indicators
		rf_pulse();
		cyc(3);
		chk("rf_off", rf_oe, 1'b0);
		wr(`OFS_CTRL, 32'h10);
		cyc(3);
		chk("rf_on", {rf_oe, rf_o}, 2'b11);
		wr(`OFS_IRQ_STATUS, 32'h1);
		cyc(3);
		chk("rf_clear", {rf_oe, rf_o}, 2'b10);
		chk("lock_off", lock_out, 1'b0);
		wr(`OFS_CTRL, 32'h30);
		cyc(3);
		chk("lock_on", lock_out, 1'b1);
		@(posedge clk_sys) loop_locked <= 1'b0;
		cyc(3);
		chk("lock_lost", lock_out, 1'b0);
		@(posedge clk_sys) loop_locked <= 1'b1;
		// Shared output modes with an unmasked interrupt pending
		wr(`OFS_IRQ_STATUS, 32'hf);
		wr(`OFS_IRQ_MASK, 32'h1);
		rf_pulse();
		cyc(3);
		chk("irq_set", irq, 1'b1);
		for (int k = 0; k < 5; k++) begin
			wr(`OFS_IRQ_CFG, {27'h0, cfg_t[k]});
			cyc(3);
			chk("irq_pin", {int_oe, int_o}, pin_t[k]);
		end
		wr(`OFS_IRQ_CFG, 32'h4);
		wr(`OFS_IRQ_MASK, 32'h0);
		cyc(3);
		chk("irq_masked", {irq, int_oe}, 2'b00);
		rc("status_sticky", `OFS_IRQ_STATUS, 32'h1);
		wr(`OFS_IRQ_CFG, 32'h1);
		cyc(3);
		chk("los_active", {int_oe, int_o}, 2'b10);
		@(posedge clk_sys) activity_group_a <= 1'b0;
		cyc(3);
		chk("los_lost", {int_oe, int_o}, 2'b11);
		@(posedge clk_sys) activity_group_a <= 1'b1;
		// Serial frames in all four clock modes; device returns its status
		wr(`OFS_IRQ_MASK, 32'h8);
		for (int m = 0; m < 4; m++) begin
			wr(`OFS_IRQ_STATUS, 32'hf);
			rf_pulse();
			i_spi_host_model.xfer(m[1], m[0], 1'b1, 8'h5a, rx);
			cyc(8);
			chk("ser_rx", rx, 8'h01);
			rc("ser_status", `OFS_IRQ_STATUS, 32'h9);
			rc("ser_byte", `OFS_STATE, 32'h5a06);
			chk("ser_irq", irq, 1'b1);
		end
		wr(`OFS_IRQ_STATUS, 32'hf);
		i_spi_host_model.xfer(1'b0, 1'b0, 1'b0, 8'hff, rx);
		cyc(8);
		rc("ser_ignored", `OFS_IRQ_STATUS, 32'h0);
		rc("ser_hold", `OFS_STATE, 32'h5a06);
		chk("sdo_idle", {irq, sdo_oe}, 2'b00);
		rc("unmapped", 8'h20, 32'h0);
		conclude();
	end
endmodule : tb
`default_nettype wire
